// ===== verilog/tenbt_regs_pkg.sv
// Constants, field positions and carrier types for the 10BASE-T control
// and self-test extension register block.
// Assumes a single 100 MHz core clock and a plain register port.
package tenbt_regs_pkg;

  localparam logic [4:0]  ADDR_CTRL_STATUS = 5'h1A;
  localparam logic [4:0]  ADDR_SELFTEST    = 5'h1B;
  localparam logic [4:0]  ADDR_SUMMARY     = 5'h10;
  localparam logic [4:0]  ADDR_IRQ_STATUS  = 5'h1C;
  localparam logic [4:0]  ADDR_IRQ_CLEAR   = 5'h1E;
  localparam logic [4:0]  ADDR_IRQ_ENABLE  = 5'h1F;

  localparam int CS_LINK_PULSE_TX_DISABLE_BIT   = 7;
  localparam int CS_FORCE_BIT    = 6;
  localparam int CS_POL_BIT      = 4;
  localparam int CS_HB_DIS_BIT   = 1;
  localparam int CS_JAB_DIS_BIT  = 0;
  localparam int SUM_POL_BIT     = 12;
  localparam int ST_CONT_BIT     = 5;
  localparam int ST_PATT_EN_BIT  = 4;

  localparam logic [7:0]  CS_LOW_RESET   = 8'h04;
  localparam logic [7:0]  CS_WR_MASK     = 8'hEF;
  localparam logic [7:0]  ST_LOW_RESET   = 8'h00;
  localparam logic [7:0]  TALLY_MAX      = 8'hFF;
  localparam logic [2:0]  IRQ_RESET      = 3'h0;

  localparam int IRQ_POL_BIT   = 0;
  localparam int IRQ_SAT_BIT   = 1;
  localparam int IRQ_START_BIT = 2;

  typedef enum logic [1:0] {
    PATT_DATA_EOP0 = 2'h0,
    PATT_DATA_EOP1 = 2'h1,
    PATT_LINK_PULS = 2'h2,
    PATT_MAN_ONES  = 2'h3
  } test_pattern_choice_t;

  typedef struct packed {
    logic                 link_pulse_tx_disable;
    logic                 force_good_link;
    logic                 sqe_test_enable;
    logic                 runaway_tx_guard_enable;
    logic                 selftest_nonstop_tx;
    logic                 pattern_active;
    test_pattern_choice_t test_pattern_choice;
  } tenbt_ctrl_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage : tenbt_regs_pkg

// ===== verilog/sat_tally.sv
// Saturating error tally with synchronous restart.
// Assumes restart and error pulses come from the core clock domain.
`timescale 1ns/1ns
module sat_tally (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_restart,
  input  wire logic       i_count,
  output logic [7:0]      o_value,
  output logic            o_saturated
);
  logic [7:0] value_q;
  logic [7:0] value_d;

  always_comb
  begin
    value_d = value_q;
    if (i_restart)
    begin
      value_d = 8'h00;
    end
    else if (i_count && (value_q != tenbt_regs_pkg::TALLY_MAX))
    begin
      value_d = value_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      value_q <= 8'h00;
    end
    else
    begin
      value_q <= value_d;
    end
  end

  assign o_value     = value_q;
  assign o_saturated = (value_q == tenbt_regs_pkg::TALLY_MAX);
endmodule : sat_tally

// ===== verilog/tenbt_ctrl_regs.sv
// Control/status and self-test extension registers of the 10/100 PHY.
// Assumes a one-cycle register port and polarity, bad nibble and self-test start
// inputs from PHY logic that may be asynchronous, so they pass two flip-flops first.
`timescale 1ns/1ns
module tenbt_ctrl_regs (
  input  wire logic                        i_clk,
  input  wire logic                        i_arst_n,
  input  wire logic [4:0]                  i_addr,
  input  wire logic [15:0]                 i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [15:0]                 o_rdata,
  input  wire logic                        i_pol_reversed,
  input  wire logic                        i_bad_nibble,
  input  wire logic                        i_selftest_start,
  input  wire logic                        i_rx_link_good_10,
  input  wire logic                        i_speed_100,
  input  wire logic                        i_full_duplex,
  input  wire logic [1:0]                  i_test_pattern_choice,
  output tenbt_regs_pkg::tenbt_ctrl_t      o_ctrl,
  output logic                             o_link_good_10,
  output logic                             o_irq
);
  tenbt_regs_pkg::reg_req_t req;

  logic [2:0]  sync1_q;
  logic [2:0]  sync2_q;
  logic [2:0]  sync_d;
  logic        start_prev_q;
  logic        start_prev_d;
  logic        start_pulse;

  logic [7:0]  cs_low_q;
  logic [7:0]  cs_low_d;
  logic [7:0]  st_low_q;
  logic [7:0]  st_low_d;
  logic        pol_q;
  logic        pol_d;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_stat_d;
  logic [2:0]  irq_en_q;
  logic [2:0]  irq_en_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        sat_prev_q;
  logic        sat_prev_d;

  logic [7:0]  tally;
  logic        tally_sat;
  logic [2:0]  events;

  assign req.addr  = i_addr;
  assign req.wdata = i_wdata;
  assign req.wr    = i_wr;
  assign req.rd    = i_rd;

  // Pin inputs: polarity, bad nibble, self-test start
  assign sync_d = {i_selftest_start, i_bad_nibble, i_pol_reversed};

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= sync_d;
      sync2_q <= sync1_q;
    end
  end

  assign start_prev_d = sync2_q[2];
  assign start_pulse  = sync2_q[2] && !start_prev_q;

  sat_tally u_tally (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_restart   (start_pulse),
    .i_count     (sync2_q[1]),
    .o_value     (tally),
    .o_saturated (tally_sat)
  );

  assign sat_prev_d = tally_sat;

  // Register writes and latched polarity
  always_comb
  begin
    cs_low_d = cs_low_q;
    st_low_d = st_low_q;
    irq_en_d = irq_en_q;
    pol_d    = pol_q;
    if (req.wr && (req.addr == tenbt_regs_pkg::ADDR_CTRL_STATUS))
    begin
      cs_low_d = req.wdata[7:0] & tenbt_regs_pkg::CS_WR_MASK;
    end
    if (req.wr && (req.addr == tenbt_regs_pkg::ADDR_SELFTEST))
    begin
      st_low_d = req.wdata[7:0];
    end
    if (req.wr && (req.addr == tenbt_regs_pkg::ADDR_IRQ_ENABLE))
    begin
      irq_en_d = req.wdata[2:0];
    end
    if (req.rd && (req.addr == tenbt_regs_pkg::ADDR_CTRL_STATUS))
    begin
      pol_d = 1'b0;
    end
    if (sync2_q[0])
    begin
      pol_d = 1'b1;
    end
  end

  // Interrupt status: set wins over clear
  assign events[tenbt_regs_pkg::IRQ_POL_BIT]   = sync2_q[0] && !pol_q;
  assign events[tenbt_regs_pkg::IRQ_SAT_BIT]   = tally_sat && !sat_prev_q;
  assign events[tenbt_regs_pkg::IRQ_START_BIT] = start_pulse;

  always_comb
  begin
    irq_stat_d = irq_stat_q;
    if (req.wr && (req.addr == tenbt_regs_pkg::ADDR_IRQ_CLEAR))
    begin
      irq_stat_d = irq_stat_q & ~req.wdata[2:0];
    end
    irq_stat_d = irq_stat_d | events;
  end

  // Read mux, data one cycle after the strobe
  always_comb
  begin
    rdata_d = 16'h0000;
    if (req.rd)
    begin
      case (req.addr)
        tenbt_regs_pkg::ADDR_CTRL_STATUS:
        begin
          rdata_d[7:0] = cs_low_q;
          rdata_d[tenbt_regs_pkg::CS_POL_BIT] = pol_q;
        end
        tenbt_regs_pkg::ADDR_SELFTEST:
        begin
          rdata_d = {tally, st_low_q};
        end
        tenbt_regs_pkg::ADDR_SUMMARY:
        begin
          rdata_d[tenbt_regs_pkg::SUM_POL_BIT] = pol_q;
        end
        tenbt_regs_pkg::ADDR_IRQ_STATUS:
        begin
          rdata_d[2:0] = irq_stat_q;
        end
        tenbt_regs_pkg::ADDR_IRQ_ENABLE:
        begin
          rdata_d[2:0] = irq_en_q;
        end
        default:
        begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cs_low_q     <= tenbt_regs_pkg::CS_LOW_RESET;
      st_low_q     <= tenbt_regs_pkg::ST_LOW_RESET;
      pol_q        <= 1'b0;
      irq_stat_q   <= tenbt_regs_pkg::IRQ_RESET;
      irq_en_q     <= tenbt_regs_pkg::IRQ_RESET;
      rdata_q      <= 16'h0000;
      start_prev_q <= 1'b0;
      sat_prev_q   <= 1'b0;
    end
    else
    begin
      cs_low_q     <= cs_low_d;
      st_low_q     <= st_low_d;
      pol_q        <= pol_d;
      irq_stat_q   <= irq_stat_d;
      irq_en_q     <= irq_en_d;
      rdata_q      <= rdata_d;
      start_prev_q <= start_prev_d;
      sat_prev_q   <= sat_prev_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq   = |(irq_stat_q & irq_en_q);

  // Control outputs toward the 10 Mb datapath
  assign o_ctrl.link_pulse_tx_disable =
    cs_low_q[tenbt_regs_pkg::CS_LINK_PULSE_TX_DISABLE_BIT];
  assign o_ctrl.force_good_link = cs_low_q[tenbt_regs_pkg::CS_FORCE_BIT];
  assign o_ctrl.sqe_test_enable = !i_speed_100 && !i_full_duplex
    && !cs_low_q[tenbt_regs_pkg::CS_HB_DIS_BIT];
  assign o_ctrl.runaway_tx_guard_enable = !i_speed_100
    && !cs_low_q[tenbt_regs_pkg::CS_JAB_DIS_BIT];
  assign o_ctrl.selftest_nonstop_tx = st_low_q[tenbt_regs_pkg::ST_CONT_BIT];
  assign o_ctrl.pattern_active = st_low_q[tenbt_regs_pkg::ST_PATT_EN_BIT];
  assign o_ctrl.test_pattern_choice =
    tenbt_regs_pkg::test_pattern_choice_t'(i_test_pattern_choice);
  assign o_link_good_10 = i_rx_link_good_10
    || cs_low_q[tenbt_regs_pkg::CS_FORCE_BIT];
endmodule : tenbt_ctrl_regs

// ===== test/tenbt_ctrl_regs_monitor.sv
// Port checker for the control/status and self-test registers.
// Assumes it is bound to tenbt_ctrl_regs with one core clock.
`timescale 1ns/1ns
module tenbt_ctrl_regs_monitor (
  input wire logic                        i_clk,
  input wire logic                        i_arst_n,
  input wire logic [4:0]                  i_addr,
  input wire logic [15:0]                 i_wdata,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire logic [15:0]                 o_rdata,
  input wire logic                        i_pol_reversed,
  input wire logic                        i_rx_link_good_10,
  input wire logic                        i_speed_100,
  input wire logic                        i_full_duplex,
  input wire tenbt_regs_pkg::tenbt_ctrl_t o_ctrl,
  input wire logic                        o_link_good_10,
  input wire logic                        o_irq
);
  logic rd_cs;
  logic rd_sum;
  assign rd_cs = i_rd && i_addr == tenbt_regs_pkg::ADDR_CTRL_STATUS;
  assign rd_sum = i_rd && i_addr == tenbt_regs_pkg::ADDR_SUMMARY;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not idle");
  a_link_force: assert property (o_link_good_10 == (i_rx_link_good_10 | o_ctrl.force_good_link))
    else $error("link status wrong");
  a_sqe_off: assert property ((i_speed_100 || i_full_duplex) |-> !o_ctrl.sqe_test_enable)
    else $error("heartbeat not off");
  a_guard_speed: assert property (i_speed_100 |-> !o_ctrl.runaway_tx_guard_enable)
    else $error("jabber guard on at 100");
  a_cs_write: assert property (i_wr && i_addr == tenbt_regs_pkg::ADDR_CTRL_STATUS |=>
    o_ctrl.link_pulse_tx_disable == $past(i_wdata[7]) && o_ctrl.force_good_link == $past(i_wdata[6]))
    else $error("control write lost");
  a_st_write: assert property (i_wr && i_addr == tenbt_regs_pkg::ADDR_SELFTEST |=>
    o_ctrl.selftest_nonstop_tx == $past(i_wdata[5]) && o_ctrl.pattern_active == $past(i_wdata[4]))
    else $error("self-test write lost");
  a_pol_clear: assert property ((!i_pol_reversed)[*4] ##0 rd_cs ##1 rd_cs |=> !o_rdata[4])
    else $error("polarity not cleared");
  a_summary_keep: assert property (rd_sum ##1 (rd_sum && o_rdata[12]) |=> o_rdata[12])
    else $error("summary read cleared polarity");
  a_irq_masked: assert property (i_wr && i_addr == tenbt_regs_pkg::ADDR_IRQ_ENABLE &&
    i_wdata[2:0] == 3'h0 |-> ##2 !o_irq)
    else $error("masked interrupt high");
  c_irq: cover property ($rose(o_irq));
  c_pol: cover property (rd_cs ##1 o_rdata[4]);
  c_max: cover property (i_rd ##1 o_rdata[15:8] == 8'hFF);
endmodule : tenbt_ctrl_regs_monitor

bind tenbt_ctrl_regs tenbt_ctrl_regs_monitor mon (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_pol_reversed, .i_rx_link_good_10, .i_speed_100, .i_full_duplex, .o_ctrl,
  .o_link_good_10, .o_irq);

// ===== test/tenbt_ctrl_regs_bench.sv
// Self-checking bench for the control/status and self-test registers.
// Assumes the checker file is compiled beside the design.
`timescale 1ns/1ns
module tenbt_ctrl_regs_bench;
  logic                        i_clk = 1'b0;
  logic                        i_arst_n = 1'b0;
  logic [4:0]                  i_addr = 5'h00;
  logic [15:0]                 i_wdata = 16'h0000;
  logic                        i_wr = 1'b0, i_rd = 1'b0, i_pol_reversed = 1'b0;
  logic                        i_bad_nibble = 1'b0, i_selftest_start = 1'b0;
  logic                        i_rx_link_good_10 = 1'b0, i_speed_100 = 1'b0;
  logic                        i_full_duplex = 1'b0, o_link_good_10, o_irq, cs;
  logic [1:0]                  i_test_pattern_choice = 2'h0;
  logic [15:0]                 o_rdata, d;
  tenbt_regs_pkg::tenbt_ctrl_t o_ctrl;
  int                          failures = 0, compares = 0;
  // Rows: write flag, address, write data, expected read
  logic [37:0]                 rows [10] = '{{1'b0, 5'h1A, 16'h0000, 16'h0004},
    {1'b0, 5'h1B, 16'h0000, 16'h0000}, {1'b0, 5'h1C, 16'h0000, 16'h0000},
    {1'b1, 5'h1A, 16'hFFC7, 16'h00C7}, {1'b1, 5'h1A, 16'h0004, 16'h0004},
    {1'b1, 5'h1B, 16'h0010, 16'h0010}, {1'b1, 5'h1F, 16'h0007, 16'h0007},
    {1'b1, 5'h1E, 16'h0007, 16'h0000}, {1'b1, 5'h05, 16'hFFFF, 16'h0000},
    {1'b1, 5'h10, 16'hFFFF, 16'h0000}};
  always #5 i_clk = ~i_clk;
  tenbt_ctrl_regs uut (.i_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_pol_reversed, .i_bad_nibble, .i_selftest_start, .i_rx_link_good_10, .i_speed_100,
    .i_full_duplex, .i_test_pattern_choice, .o_ctrl, .o_link_good_10, .o_irq);
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd
  task automatic tally_and_finish;
    if (failures == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #50000;
    failures++;
    tally_and_finish;
  end
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    cyc(1);
    foreach (rows[i])
    begin
      if (rows[i][37])
        wr(rows[i][36:32], rows[i][31:16]);
      rd(rows[i][36:32]);
      chk("register", rows[i][15:0], d);
    end
    for (int k = 0; k < 8; k++)
    begin
      cs = k[2];
      wr(5'h1A, cs ? 16'h00C7 : 16'h0004);
      {i_speed_100, i_full_duplex} <= k[1:0];
      i_rx_link_good_10 <= k[0];
      i_test_pattern_choice <= k[1:0];
      cyc(1);
      d = {8'h00, cs, cs, !cs && k[1:0] == 2'h0, !cs && !k[1], 2'b01, k[1:0]};
      chk("ctrl", d, {8'h00, o_ctrl});
      chk("link", {15'h0000, k[0] | cs}, 16'(o_link_good_10));
    end
    wr(5'h1A, 16'h0004);
    wr(5'h1F, 16'h0001);
    i_pol_reversed <= 1'b1;
    cyc(1);
    i_pol_reversed <= 1'b0;
    cyc(5);
    chk("irq set", 16'h0001, 16'(o_irq));
    wr(5'h1F, 16'h0000);
    cyc(1);
    chk("irq masked", 16'h0000, 16'(o_irq));
    wr(5'h1F, 16'h0001);
    rd(5'h10);
    chk("summary", 16'h1000, d);
    rd(5'h10);
    chk("summary kept", 16'h1000, d);
    rd(5'h1A);
    chk("polarity", 16'h0014, d);
    rd(5'h1A);
    chk("polarity clear", 16'h0004, d);
    rd(5'h10);
    chk("summary clear", 16'h0000, d);
    wr(5'h1E, 16'h0001);
    cyc(1);
    chk("irq clear", 16'h0000, 16'(o_irq));
    wr(5'h1A, 16'h0005);
    wr(5'h1B, 16'h0030);
    wr(5'h1F, 16'h0006);
    i_selftest_start <= 1'b1;
    cyc(5);
    chk("start irq", 16'h0001, 16'(o_irq));
    wr(5'h1E, 16'h0007);
    i_bad_nibble <= 1'b1;
    cyc(3);
    i_bad_nibble <= 1'b0;
    cyc(4);
    rd(5'h1B);
    chk("tally", 16'h0330, d);
    i_bad_nibble <= 1'b1;
    cyc(300);
    i_bad_nibble <= 1'b0;
    cyc(4);
    rd(5'h1B);
    chk("tally max", 16'hFF30, d);
    chk("max irq", 16'h0001, 16'(o_irq));
    i_selftest_start <= 1'b0;
    cyc(4);
    i_selftest_start <= 1'b1;
    cyc(5);
    rd(5'h1B);
    chk("tally restart", 16'h0030, d);
    i_arst_n <= 1'b0;
    cyc(2);
    i_arst_n <= 1'b1;
    cyc(1);
    rd(5'h1A);
    chk("reset ctrl", 16'h0004, d);
    rd(5'h1B);
    chk("reset tally", 16'h0000, d);
    chk("reset irq", 16'h0000, 16'(o_irq));
    tally_and_finish;
  end
endmodule : tenbt_ctrl_regs_bench
